// ==== dmm_map.svh ====
// register map, field positions and reset values of the direct memory mover
`ifndef DMM_MAP_SVH
`define DMM_MAP_SVH
`define DMM_NCH 4
`define DMM_GLOB_BIT 7
`define DMM_CH_SEL 6:5
`define DMM_REG_SEL 4:2
`define DMM_OFS_PRIO 8'h80
`define DMM_OFS_ISTAT 8'h84
`define DMM_OFS_IMASK 8'h88
`define DMM_REG_CTRL 3'h0
`define DMM_REG_BLOCK 3'h1
`define DMM_REG_REPEAT 3'h2
`define DMM_REG_SRC 3'h3
`define DMM_REG_DST 3'h4
`define DMM_REG_STATUS 3'h5
`define DMM_REG_CUR_SRC 3'h6
`define DMM_REG_CUR_DST 3'h7
`define DMM_CTRL_EN 0
`define DMM_CTRL_SWREQ 1
`define DMM_CTRL_BURST 3:2
`define DMM_CTRL_SINGLE 4
`define DMM_CTRL_TRIG 6:5
`define DMM_CTRL_SRCDIR 9:8
`define DMM_CTRL_DSTDIR 11:10
`define DMM_CTRL_SRCRLD 13:12
`define DMM_CTRL_DSTRLD 15:14
`define DMM_CTRL_LINK 16
`define DMM_BLK_FIELD 15:0
`define DMM_REP_FIELD 7:0
`define DMM_ADDR_FIELD 23:0
`define DMM_STAT_EN 0
`define DMM_STAT_PEND 1
`define DMM_STAT_ACTIVE 2
`define DMM_STAT_REP 16:8
`define DMM_PRIO_FIXED 0
`define DMM_IST_DONE 3:0
`define DMM_IST_ERR 7:4
`define DMM_IMASK_RST 8'h00
`define DMM_WORD_RST 32'h0000_0000
`define DMM_ADDR_RST 24'h00_0000
`define DMM_BLK_MAX 17'h1_0000
`define DMM_REP_MAX 9'h100
`endif

// ==== dmm_pkg.sv ====
// types shared by the direct memory mover modules
package dmm_pkg;
  typedef enum logic [1:0] {DIR_FIXED = 2'h0, DIR_INC = 2'h1, DIR_DEC = 2'h2, DIR_RSVD = 2'h3} dir_e;
  typedef enum logic [1:0] {RLD_NONE = 2'h0, RLD_BURST = 2'h1, RLD_BLOCK = 2'h2, RLD_TRANS = 2'h3} rld_e;
  typedef enum logic [1:0] {TRIG_SW = 2'h0, TRIG_PERIPH = 2'h1, TRIG_EVENT = 2'h2, TRIG_RSVD = 2'h3} trig_e;
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_READ = 3'b010, ST_WRITE = 3'b100} eng_state_e;
  typedef logic [23:0] addr_t;
  typedef struct packed {
    logic en;
    logic single;
    logic [1:0] burst;
    trig_e trig;
    dir_e src_dir;
    dir_e dst_dir;
    rld_e src_rld;
    rld_e dst_rld;
    logic link;
    logic [15:0] blk_size;
    logic [7:0] rep;
    addr_t src;
    addr_t dst;
  } chan_cfg_s;
  typedef struct packed {
    logic load;
    logic rd_adv;
    logic wr_adv;
    logic burst_end;
  } chan_step_s;
  typedef struct packed {
    addr_t src;
    addr_t dst;
    logic [16:0] blk_left;
    logic [8:0] rep_left;
  } chan_stat_s;
endpackage

// ==== chan_arbiter.sv ====
// picks one requesting channel, fixed or round robin priority
`include "dmm_map.svh"
module chan_arbiter import dmm_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] req,
  input wire logic fixed,
  input wire logic take,
  output logic grant_valid,
  output logic [1:0] grant_idx
);
  logic [1:0] last_r;
  logic [1:0] cand;

  always_comb begin
    cand = 2'h0;
    grant_valid = 1'b0;
    grant_idx = 2'h0;
    for (int i = 0; i < `DMM_NCH; i++) begin
      cand = fixed ? 2'(i) : 2'(last_r + 2'(i) + 2'h1);
      if (!grant_valid && req[cand]) begin
        grant_valid = 1'b1;
        grant_idx = cand;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_r <= 2'h3;
    end else if (take) begin
      last_r <= grant_idx;
    end
  end

  a_fixed_low_wins: assert property (@(posedge clk) disable iff (!resetn)
    fixed && req[0] |-> grant_valid && grant_idx == 2'h0)
    else $error("fixed priority did not grant channel 0");
  a_rr_rotates: assert property (@(posedge clk) disable iff (!resetn)
    !fixed && req[2'(last_r + 2'h1)] |-> grant_valid && grant_idx == 2'(last_r + 2'h1))
    else $error("round robin did not move to the next channel");
endmodule

// ==== chan_counter.sv ====
// per-channel address, block and repeat counters with reload
`include "dmm_map.svh"
module chan_counter import dmm_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input chan_cfg_s cfg,
  input chan_step_s step,
  output chan_stat_s stat,
  output logic blk_end,
  output logic trans_end
);
  addr_t src_r;
  addr_t dst_r;
  logic [16:0] blk_r;
  logic [8:0] rep_r;
  logic [16:0] blk_full;
  logic [8:0] rep_full;
  logic src_rld;
  logic dst_rld;

  function automatic addr_t step_addr(input addr_t a, input dir_e d);
    case (d)
      DIR_INC: return addr_t'(a + 24'h00_0001);
      DIR_DEC: return addr_t'(a - 24'h00_0001);
      default: return a;
    endcase
  endfunction

  function automatic logic reload_now(input rld_e m, input logic be, input logic ble, input logic te);
    case (m)
      RLD_BURST: return be;
      RLD_BLOCK: return ble;
      RLD_TRANS: return te;
      default: return 1'b0;
    endcase
  endfunction

  assign blk_full = (cfg.blk_size == 16'h0000) ? `DMM_BLK_MAX : {1'b0, cfg.blk_size};
  assign rep_full = (cfg.rep == 8'h00) ? `DMM_REP_MAX : {1'b0, cfg.rep};
  assign blk_end = step.wr_adv && blk_r == 17'h0_0001;
  assign trans_end = blk_end && rep_r == 9'h001;
  assign src_rld = reload_now(cfg.src_rld, step.burst_end, blk_end, trans_end);
  assign dst_rld = reload_now(cfg.dst_rld, step.burst_end, blk_end, trans_end);
  assign stat = '{src: src_r, dst: dst_r, blk_left: blk_r, rep_left: rep_r};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      src_r <= `DMM_ADDR_RST;
    end else if (step.load || src_rld) begin
      src_r <= cfg.src;
    end else if (step.rd_adv) begin
      src_r <= step_addr(src_r, cfg.src_dir);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dst_r <= `DMM_ADDR_RST;
    end else if (step.load || dst_rld) begin
      dst_r <= cfg.dst;
    end else if (step.wr_adv) begin
      dst_r <= step_addr(dst_r, cfg.dst_dir);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blk_r <= 17'h0_0000;
      rep_r <= 9'h000;
    end else if (step.load) begin
      blk_r <= blk_full;
      rep_r <= rep_full;
    end else if (step.wr_adv) begin
      blk_r <= trans_end ? 17'h0_0000 : (blk_end ? blk_full : 17'(blk_r - 17'h0_0001));
      if (blk_end && !trans_end) begin
        rep_r <= 9'(rep_r - 9'h001);
      end
    end
  end

  a_src_increment: assert property (@(posedge clk) disable iff (!resetn)
    step.rd_adv && !step.load && !src_rld && cfg.src_dir == DIR_INC |=> src_r == addr_t'($past(src_r) + 24'h00_0001))
    else $error("source address did not increment");
  a_dst_burst_reload: assert property (@(posedge clk) disable iff (!resetn)
    step.burst_end && cfg.dst_rld == RLD_BURST |=> dst_r == $past(cfg.dst))
    else $error("destination not restored after burst");
  a_block_refill: assert property (@(posedge clk) disable iff (!resetn)
    blk_end && !trans_end && !step.load |=> blk_r == $past(blk_full) && rep_r == 9'($past(rep_r) - 9'h001))
    else $error("block counter not refilled at block end");
  a_trans_last: assert property (@(posedge clk) disable iff (!resetn)
    trans_end && !step.load |=> blk_r == 17'h0_0000 ##1 (blk_r == 17'h0_0000 || $past(step.load)))
    else $error("counter not emptied at transaction end");
endmodule

// ==== direct_memory_mover.sv ====
// four-channel direct memory mover: Avalon-MM registers, burst engine and bus master ports
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`include "dmm_map.svh"
module direct_memory_mover import dmm_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic rd_req,
  output logic [23:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_wait,
  input wire logic rd_error,
  output logic wr_req,
  output logic [23:0] wr_addr,
  output logic [7:0] wr_data,
  input wire logic wr_wait,
  input wire logic wr_error,
  input wire logic [3:0] periph_req,
  input wire logic [3:0] event_in,
  output logic irq
);
  chan_cfg_s cfg_r [`DMM_NCH];
  chan_step_s step [`DMM_NCH];
  chan_stat_s stat [`DMM_NCH];
  logic [3:0] blk_end_v;
  logic [3:0] trans_end_v;
  logic [3:0] done_v;
  logic [3:0] err_v;
  logic [3:0] link_v;
  logic [3:0] ch_wr;
  logic [3:0] pend_r;
  logic [3:0] arb_req;
  logic [7:0] istat_r;
  logic [7:0] imask_r;
  logic fixed_prio_r;
  eng_state_e state_r;
  logic [1:0] sel_r;
  logic [3:0] cnt_r;
  logic [2:0] idx_r;
  logic [7:0] buf_r [8];
  logic [31:0] rdata_r;
  logic rack_r;
  logic [31:0] reg_word;
  logic [31:0] wmerged;
  logic is_glob;
  logic [1:0] ch_sel;
  logic [2:0] reg_sel;
  logic grant_valid;
  logic [1:0] grant_idx;
  logic take;
  logic [3:0] bbytes;
  logic [3:0] take_cnt;
  logic rd_fire;
  logic wr_fire;
  logic rd_last;
  logic wr_last;

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  function automatic logic [31:0] ctrl_word(input chan_cfg_s c);
    logic [31:0] w;
    w = `DMM_WORD_RST;
    w[`DMM_CTRL_EN] = c.en;
    w[`DMM_CTRL_BURST] = c.burst;
    w[`DMM_CTRL_SINGLE] = c.single;
    w[`DMM_CTRL_TRIG] = c.trig;
    w[`DMM_CTRL_SRCDIR] = c.src_dir;
    w[`DMM_CTRL_DSTDIR] = c.dst_dir;
    w[`DMM_CTRL_SRCRLD] = c.src_rld;
    w[`DMM_CTRL_DSTRLD] = c.dst_rld;
    w[`DMM_CTRL_LINK] = c.link;
    return w;
  endfunction

  // register bus decode
  assign is_glob = avs_address[`DMM_GLOB_BIT];
  assign ch_sel = avs_address[`DMM_CH_SEL];
  assign reg_sel = avs_address[`DMM_REG_SEL];

  always_comb begin
    reg_word = `DMM_WORD_RST;
    if (is_glob) begin
      case ({avs_address[7:2], 2'b00})
        `DMM_OFS_PRIO: reg_word[`DMM_PRIO_FIXED] = fixed_prio_r;
        `DMM_OFS_ISTAT: reg_word[7:0] = istat_r;
        `DMM_OFS_IMASK: reg_word[7:0] = imask_r;
        default: reg_word = `DMM_WORD_RST;
      endcase
    end else begin
      case (reg_sel)
        `DMM_REG_CTRL: reg_word = ctrl_word(cfg_r[ch_sel]);
        `DMM_REG_BLOCK: reg_word[`DMM_BLK_FIELD] = cfg_r[ch_sel].blk_size;
        `DMM_REG_REPEAT: reg_word[`DMM_REP_FIELD] = cfg_r[ch_sel].rep;
        `DMM_REG_SRC: reg_word[`DMM_ADDR_FIELD] = cfg_r[ch_sel].src;
        `DMM_REG_DST: reg_word[`DMM_ADDR_FIELD] = cfg_r[ch_sel].dst;
        `DMM_REG_STATUS: begin
          reg_word[`DMM_STAT_EN] = cfg_r[ch_sel].en;
          reg_word[`DMM_STAT_PEND] = pend_r[ch_sel];
          reg_word[`DMM_STAT_ACTIVE] = state_r != ST_IDLE && sel_r == ch_sel;
          reg_word[`DMM_STAT_REP] = stat[ch_sel].rep_left;
        end
        `DMM_REG_CUR_SRC: reg_word[`DMM_ADDR_FIELD] = stat[ch_sel].src;
        `DMM_REG_CUR_DST: reg_word[`DMM_ADDR_FIELD] = stat[ch_sel].dst;
        default: reg_word = `DMM_WORD_RST;
      endcase
    end
  end

  assign wmerged = merge_be(reg_word, avs_writedata, avs_byteenable);
  // reads wait one cycle for registered data, writes never wait
  assign avs_waitrequest = avs_read && !rack_r;
  assign avs_readdata = rdata_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rack_r <= 1'b0;
      rdata_r <= `DMM_WORD_RST;
    end else begin
      rack_r <= avs_read && !rack_r;
      if (avs_read && !rack_r) begin
        rdata_r <= reg_word;
      end
    end
  end

  // per-channel events
  always_comb begin
    for (int c = 0; c < `DMM_NCH; c++) begin
      ch_wr[c] = avs_write && !is_glob && ch_sel == 2'(c);
      err_v[c] = sel_r == 2'(c) && ((rd_fire && rd_error) || (wr_fire && wr_error));
      step[c].rd_adv = rd_fire && !rd_error && sel_r == 2'(c);
      step[c].wr_adv = wr_fire && !wr_error && sel_r == 2'(c);
      step[c].burst_end = step[c].wr_adv && wr_last;
      done_v[c] = trans_end_v[c];
      arb_req[c] = pend_r[c] && cfg_r[c].en;
    end
    for (int c = 0; c < `DMM_NCH; c++) begin
      link_v[c] = done_v[c ^ 1] && cfg_r[c ^ 1].link;
      step[c].load = link_v[c] ||
        (ch_wr[c] && reg_sel == `DMM_REG_CTRL && wmerged[`DMM_CTRL_EN] && !cfg_r[c].en);
    end
  end

  for (genvar g = 0; g < `DMM_NCH; g++) begin : g_chan
    chan_counter u_cnt (
      .clk(clk),
      .resetn(resetn),
      .cfg(cfg_r[g]),
      .step(step[g]),
      .stat(stat[g]),
      .blk_end(blk_end_v[g]),
      .trans_end(trans_end_v[g])
    );
  end

  // channel configuration
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < `DMM_NCH; c++) begin
        cfg_r[c] <= '0;
      end
    end else begin
      for (int c = 0; c < `DMM_NCH; c++) begin
        if (ch_wr[c]) begin
          case (reg_sel)
            `DMM_REG_CTRL: begin
              cfg_r[c].en <= wmerged[`DMM_CTRL_EN];
              cfg_r[c].burst <= wmerged[`DMM_CTRL_BURST];
              cfg_r[c].single <= wmerged[`DMM_CTRL_SINGLE];
              cfg_r[c].trig <= trig_e'(wmerged[`DMM_CTRL_TRIG]);
              cfg_r[c].src_dir <= dir_e'(wmerged[`DMM_CTRL_SRCDIR]);
              cfg_r[c].dst_dir <= dir_e'(wmerged[`DMM_CTRL_DSTDIR]);
              cfg_r[c].src_rld <= rld_e'(wmerged[`DMM_CTRL_SRCRLD]);
              cfg_r[c].dst_rld <= rld_e'(wmerged[`DMM_CTRL_DSTRLD]);
              cfg_r[c].link <= wmerged[`DMM_CTRL_LINK];
            end
            `DMM_REG_BLOCK: cfg_r[c].blk_size <= wmerged[`DMM_BLK_FIELD];
            `DMM_REG_REPEAT: cfg_r[c].rep <= wmerged[`DMM_REP_FIELD];
            `DMM_REG_SRC: cfg_r[c].src <= wmerged[`DMM_ADDR_FIELD];
            `DMM_REG_DST: cfg_r[c].dst <= wmerged[`DMM_ADDR_FIELD];
            default: ;
          endcase
        end
        if (done_v[c] || err_v[c]) begin
          cfg_r[c].en <= 1'b0;
        end
        if (link_v[c]) begin
          cfg_r[c].en <= 1'b1;
        end
      end
    end
  end

  // trigger pending flags, a new trigger wins over the clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_r <= 4'h0;
    end else begin
      for (int c = 0; c < `DMM_NCH; c++) begin
        pend_r[c] <= (pend_r[c] && !(!cfg_r[c].en || done_v[c] || err_v[c] ||
                      (step[c].burst_end && (cfg_r[c].single || blk_end_v[c])))) ||
                     (ch_wr[c] && reg_sel == `DMM_REG_CTRL && avs_byteenable[0] &&
                      avs_writedata[`DMM_CTRL_SWREQ]) ||
                     (cfg_r[c].trig == TRIG_PERIPH && periph_req[c]) ||
                     (cfg_r[c].trig == TRIG_EVENT && event_in[c]) ||
                     link_v[c];
      end
    end
  end

  // global registers and interrupt
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fixed_prio_r <= 1'b0;
      imask_r <= `DMM_IMASK_RST;
      istat_r <= 8'h00;
    end else begin
      if (avs_write && is_glob && {avs_address[7:2], 2'b00} == `DMM_OFS_PRIO) begin
        fixed_prio_r <= wmerged[`DMM_PRIO_FIXED];
      end
      if (avs_write && is_glob && {avs_address[7:2], 2'b00} == `DMM_OFS_IMASK) begin
        imask_r <= wmerged[7:0];
      end
      istat_r <= (istat_r & ~((avs_write && is_glob && {avs_address[7:2], 2'b00} == `DMM_OFS_ISTAT &&
                 avs_byteenable[0]) ? avs_writedata[7:0] : 8'h00)) | {err_v, done_v};
    end
  end

  assign irq = |(istat_r & imask_r);

  chan_arbiter u_arb (
    .clk(clk),
    .resetn(resetn),
    .req(arb_req),
    .fixed(fixed_prio_r),
    .take(take),
    .grant_valid(grant_valid),
    .grant_idx(grant_idx)
  );

  // burst engine, read and write ports are separate masters
  assign take = state_r == ST_IDLE && grant_valid;
  assign bbytes = 4'(4'h1 << cfg_r[grant_idx].burst);
  assign take_cnt = (stat[grant_idx].blk_left < {13'h0000, bbytes}) ? stat[grant_idx].blk_left[3:0] : bbytes;
  assign rd_req = state_r == ST_READ;
  assign wr_req = state_r == ST_WRITE;
  assign rd_addr = stat[sel_r].src;
  assign wr_addr = stat[sel_r].dst;
  assign wr_data = buf_r[idx_r];
  assign rd_fire = rd_req && !rd_wait;
  assign wr_fire = wr_req && !wr_wait;
  assign rd_last = idx_r == 3'(cnt_r - 4'h1);
  assign wr_last = idx_r == 3'(cnt_r - 4'h1);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      sel_r <= 2'h0;
      cnt_r <= 4'h1;
      idx_r <= 3'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (take) begin
            sel_r <= grant_idx;
            cnt_r <= take_cnt;
            idx_r <= 3'h0;
            state_r <= ST_READ;
          end
        end
        ST_READ: begin
          if (rd_fire) begin
            if (rd_error) begin
              state_r <= ST_IDLE;
            end else if (rd_last) begin
              idx_r <= 3'h0;
              state_r <= ST_WRITE;
            end else begin
              idx_r <= 3'(idx_r + 3'h1);
            end
          end
        end
        ST_WRITE: begin
          if (wr_fire) begin
            if (wr_error || wr_last) begin
              state_r <= ST_IDLE;
            end else begin
              idx_r <= 3'(idx_r + 3'h1);
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        buf_r[i] <= 8'h00;
      end
    end else if (rd_fire) begin
      buf_r[idx_r] <= rd_data;
    end
  end

  a_read_stream: assert property (@(posedge clk) disable iff (!resetn)
    rd_fire && !rd_error && !rd_last |=> rd_req && idx_r == 3'($past(idx_r) + 3'h1))
    else $error("burst read stopped before its last byte");
  a_done_sets_irq: assert property (@(posedge clk) disable iff (!resetn)
    |done_v |=> (istat_r[3:0] & $past(done_v)) == $past(done_v))
    else $error("completion flag not set");
  a_link_partner: assert property (@(posedge clk) disable iff (!resetn)
    done_v[2] && cfg_r[2].link |=> cfg_r[3].en && pend_r[3])
    else $error("linked partner did not start");
  a_done_stops: assert property (@(posedge clk) disable iff (!resetn)
    |done_v |-> wr_fire && wr_last ##1 state_r == ST_IDLE && !cfg_r[$past(sel_r)].en)
    else $error("transaction end not at last write");
  a_sw_request: assert property (@(posedge clk) disable iff (!resetn)
    ch_wr[0] && reg_sel == `DMM_REG_CTRL && avs_byteenable[0] && avs_writedata[`DMM_CTRL_SWREQ] |=> pend_r[0])
    else $error("software request lost");
  a_burst_length: assert property (@(posedge clk) disable iff (!resetn)
    take |=> cnt_r == $past(take_cnt) && cnt_r <= 4'h8 && cnt_r != 4'h0)
    else $error("burst length out of range");
  a_reg_read_wait: assert property (@(posedge clk) disable iff (!resetn)
    avs_read && !rack_r |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("register read not answered in two cycles");

  c_trans_done: cover property (@(posedge clk) disable iff (!resetn) |done_v);
  c_link_start: cover property (@(posedge clk) disable iff (!resetn) |link_v);
  c_full_burst: cover property (@(posedge clk) disable iff (!resetn) wr_fire && wr_last && cnt_r == 4'h8);
  c_bus_error: cover property (@(posedge clk) disable iff (!resetn) |err_v);
endmodule

// ==== unused.sv ====
// (none)

// ==== bus_mem.sv ====
// byte-wide memory model standing on the mover's read and write ports
module bus_mem (
  input wire logic clk,
  input wire logic slow,
  input wire logic err,
  input wire logic rd_req,
  input wire logic [23:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_wait,
  output logic rd_error,
  input wire logic wr_req,
  input wire logic [23:0] wr_addr,
  input wire logic [7:0] wr_data,
  output logic wr_wait,
  output logic wr_error
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [256];
  logic tgl_r;
  initial tgl_r = 1'b0;
  always @(posedge clk) tgl_r <= ~tgl_r;
  // slow mode stalls every other cycle on each port
  assign rd_wait = slow & tgl_r;
  assign wr_wait = slow & ~tgl_r;
  // a new byte each accepted cycle; an unrequested line shows the inverse
  assign rd_data = rd_req ? mem[rd_addr[7:0]] : ~mem[rd_addr[7:0]];
  assign rd_error = err & rd_req;
  assign wr_error = err & wr_req;
  always @(posedge clk) if (wr_req && !wr_wait) mem[wr_addr[7:0]] <= wr_data;
endmodule

// ==== direct_memory_mover_tb.sv ====
// register-level bench of the direct memory mover against a memory model
module direct_memory_mover_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, resetn, avs_read, avs_write, avs_waitrequest, irq, slow, err;
  logic [7:0] avs_address, rd_data, wr_data;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] periph_req, event_in;
  logic rd_req, rd_wait, rd_error, wr_req, wr_wait, wr_error;
  logic [23:0] rd_addr, wr_addr;
  int error_cnt = 0;
  int total_checks = 0;
  direct_memory_mover u_direct_memory_mover (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_wait(rd_wait), .rd_error(rd_error), .wr_req(wr_req), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_wait(wr_wait), .wr_error(wr_error), .periph_req(periph_req),
    .event_in(event_in), .irq(irq));
  bus_mem u_bus_mem (.clk(clk), .slow(slow), .err(err), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_wait(rd_wait), .rd_error(rd_error), .wr_req(wr_req), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_wait(wr_wait), .wr_error(wr_error));
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h3c;
  endfunction
  task end_sim();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      $display("Error at %0t: got %h exp %h", $time, n, 20);
      end_sim();
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    for (int i = 0; i < 300; i++) begin
      bus(1'b0, a, 32'h0000_0000);
      if ((q & m) === e) return;
    end
    error_cnt++;
    $display("Error at %0t: got %h exp %h", $time, q & m, e);
    end_sim();
  endtask
  task prog(input logic [1:0] ch, input logic [31:0] blk, rep, src, dst, ctrl);
    logic [7:0] b;
    b = {1'b0, ch, 5'h00};
    bus(1'b1, b + 8'h04, blk);
    bus(1'b1, b + 8'h08, rep);
    bus(1'b1, b + 8'h0c, src);
    bus(1'b1, b + 8'h10, dst);
    bus(1'b1, b, ctrl);
  endtask
  task mchk(input logic [7:0] a, input logic [7:0] src);
    chk({24'h00_0000, u_bus_mem.mem[a]}, {24'h00_0000, pat(src)});
  endtask
  task pulse();
    @(posedge clk);
    event_in <= 4'h4;
    @(posedge clk);
    event_in <= 4'h0;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    resetn = 1'b0;
    {avs_read, avs_write, slow, err} = 4'h0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    periph_req = 4'h0;
    event_in = 4'h0;
    for (int i = 0; i < 256; i++) u_bus_mem.mem[i] = pat(i[7:0]);
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h88, 32'h0000_0000);
    rd(8'h84, 32'h0000_0000);
    rd(8'h00, 32'h0000_0000);
    bus(1'b1, 8'h8c, 32'hffff_ffff);
    rd(8'h8c, 32'h0000_0000);
    bus(1'b1, 8'h80, 32'h0000_0001);
    rd(8'h80, 32'h0000_0001);
    // 4-byte bursts over a 5-byte block with a stalling bus
    slow <= 1'b1;
    prog(2'd0, 32'h5, 32'h1, 32'h10, 32'h40, 32'h0000_0509);
    bus(1'b1, 8'h00, 32'h0000_050b);
    poll(8'h84, 32'h1, 32'h1);
    slow <= 1'b0;
    for (int i = 0; i < 5; i++) mchk(8'h40 + i[7:0], 8'h10 + i[7:0]);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 8'h88, 32'h0000_0001);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, 8'h84, 32'h0000_0001);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    // peripheral trigger, decrementing source into a fixed destination
    prog(2'd1, 32'h3, 32'h1, 32'h1f, 32'h60, 32'h0000_4221);
    periph_req <= 4'h2;
    poll(8'h84, 32'h2, 32'h2);
    periph_req <= 4'h0;
    mchk(8'h60, 8'h1d);
    bus(1'b1, 8'h84, 32'h0000_00ff);
    // event trigger, two repeats with block reload, then linked partner
    bus(1'b1, 8'h80, 32'h0000_0000);
    rd(8'h80, 32'h0000_0000);
    prog(2'd3, 32'h1, 32'h1, 32'h20, 32'ha0, 32'h0000_3500);
    prog(2'd2, 32'h2, 32'h2, 32'h10, 32'h80, 32'h0001_2545);
    pulse();
    poll(8'h54, 32'h0001_ff06, 32'h0000_0100);
    pulse();
    poll(8'h84, 32'hc, 32'hc);
    rd(8'h84, 32'h0000_000c);
    for (int i = 0; i < 4; i++) mchk(8'h80 + i[7:0], 8'h10 + i[0]);
    mchk(8'ha0, 8'h20);
    bus(1'b1, 8'h84, 32'h0000_00ff);
    // bus error aborts and disables the channel
    err <= 1'b1;
    prog(2'd0, 32'h4, 32'h1, 32'h10, 32'h40, 32'h0000_0509);
    bus(1'b1, 8'h00, 32'h0000_050b);
    poll(8'h84, 32'h10, 32'h10);
    err <= 1'b0;
    bus(1'b0, 8'h14, 32'h0000_0000);
    chk(q & 32'h1, 32'h0);
    end_sim();
  end
endmodule
